// ---- shared/fpw_pkg.sv ----
// Package for the four channel PWM core: offsets, fields, reset values
package fpw_pkg;
    localparam logic [7:0] OFF_CLK = 8'h40;
    localparam logic [7:0] OFF_POL = 8'h41;
    localparam logic [7:0] OFF_EN = 8'h42;
    localparam logic [7:0] OFF_PRES = 8'h43;
    localparam logic [7:0] OFF_SCAL0 = 8'h44;
    localparam logic [7:0] OFF_SCNT0 = 8'h45;
    localparam logic [7:0] OFF_SCAL1 = 8'h46;
    localparam logic [7:0] OFF_SCNT1 = 8'h47;
    localparam logic [7:0] OFF_CNT = 8'h48;
    localparam logic [7:0] OFF_PER = 8'h4c;
    localparam logic [7:0] OFF_DTY = 8'h50;
    localparam logic [7:0] OFF_CTL = 8'h54;
    localparam logic [7:0] OFF_DDR = 8'h55;
    localparam logic [7:0] OFF_PORT = 8'h56;
    localparam int POS_CON_HI = 7;
    localparam int POS_CON_LO = 6;
    localparam int POS_PCKA = 3;
    localparam int POS_PCKB = 0;
    localparam int POS_CENTER_ALIGN_SEL = 3;
    localparam logic [7:0] RST_CLK = 8'h00;
    localparam logic [7:0] RST_POL = 8'h00;
    localparam logic [7:0] RST_EN = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// ---- src/fpw_core.sv ----
// Four channel PWM core with APB register slave
//
// Decided for this implementation: the APB register port.
module fpw_core
    import fpw_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shared port pins
    input wire logic [3:0] portIn,
    output logic [3:0] portOut,
    output logic [3:0] portOe
);
    typedef struct packed {
        logic [7:0] clkCtl;
        logic [7:0] polSel;
        logic [3:0] chEn;
        logic [6:0] presCnt;
        logic [7:0] scal0;
        logic [7:0] scal1;
        logic [7:0] scnt0;
        logic [7:0] scnt1;
        logic s0;
        logic s1;
        logic [4:0] ctl;
        logic [3:0] ddr;
        logic [3:0] portData;
        logic [3:0][7:0] cnt;
        logic [3:0][7:0] perBuf;
        logic [3:0][7:0] perAct;
        logic [3:0][7:0] dtyBuf;
        logic [3:0][7:0] dtyAct;
        logic [3:0] down;
        logic [3:0] wave;
        logic [3:0] clkPrev;
        logic [3:0] live;
        logic [3:0] inS1;
        logic [3:0] inS2;
        logic [3:0] inS3;
        logic [3:0] inStable;
        logic [31:0] rdata;
    } fpw_state_t;

    fpw_state_t st_reg, st_next;

    // Tick when the low sel bits of the prescaler are all ones: every 2^sel cycles
    function automatic logic presTap(input logic [6:0] pc, input logic [2:0] sel);
        logic t;
        t = 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (i < int'(sel)) begin
                t = t && pc[i];
            end
        end
        return t;
    endfunction

    // Prescaled and scaled clock enables, one cycle pulses
    logic presRun;
    logic tickA, tickB, tickS0, tickS1;
    logic [3:0] chTick;
    logic [3:0] chEdge;
    logic [7:0] wrByte;
    logic wrEn, rdEn;
    logic [7:0] rdByte;
    logic center_align_sel;

    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    assign wrByte = pwdata[7:0];
    assign center_align_sel = st_reg.ctl[POS_CENTER_ALIGN_SEL];
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st_reg.rdata;

    always_comb begin
        // Prescaler idles with every channel off, so no ticks then
        presRun = st_reg.chEn != 4'h0;
        tickA = presRun && presTap(st_reg.presCnt, st_reg.clkCtl[POS_PCKA +: 3]);
        tickB = presRun && presTap(st_reg.presCnt, st_reg.clkCtl[POS_PCKB +: 3]);
        tickS0 = tickA && st_reg.scnt0 == 8'h01 && st_reg.s0;
        tickS1 = tickB && st_reg.scnt1 == 8'h01 && st_reg.s1;
        for (int c = 0; c < 4; c++) begin
            if (c < 2) begin
                chTick[c] = st_reg.polSel[4 + c] ? tickS0 : tickA;
            end else begin
                chTick[c] = st_reg.polSel[4 + c] ? tickS1 : tickB;
            end
            // Gate is a synchronous enable, never a gated clock
            chEdge[c] = chTick[c] && st_reg.chEn[c] && st_reg.live[c];
        end
    end

    function automatic logic [7:0] regRead(input fpw_state_t s, input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            OFF_CLK: r = s.clkCtl;
            OFF_POL: r = s.polSel;
            OFF_EN: r = {4'h0, s.chEn};
            OFF_PRES: r = {1'b0, s.presCnt};
            OFF_SCAL0: r = s.scal0;
            OFF_SCNT0: r = s.scnt0;
            OFF_SCAL1: r = s.scal1;
            OFF_SCNT1: r = s.scnt1;
            OFF_CTL: r = {3'h0, s.ctl};
            OFF_DDR: r = {4'h0, s.ddr};
            OFF_PORT: r = {4'h0, s.inStable};
            default: begin
                if (a[7:4] == OFF_CNT[7:4] && a[3:2] == 2'b10) begin
                    r = s.cnt[a[1:0]];
                end else if (a[7:4] == OFF_PER[7:4] && a[3:2] == 2'b11) begin
                    r = s.perBuf[a[1:0]];
                end else if (a[7:4] == OFF_DTY[7:4] && a[3:2] == 2'b00) begin
                    r = s.dtyBuf[a[1:0]];
                end
            end
        endcase
        return r;
    endfunction

    always_comb begin
        logic [7:0] a;
        logic [15:0] c16, p16, d16;
        logic top, bot, lat;
        a = 8'h00;
        c16 = 16'h0000;
        p16 = 16'h0000;
        d16 = 16'h0000;
        top = 1'b0;
        bot = 1'b0;
        lat = 1'b0;
        st_next = st_reg;
        rdByte = 8'h00;
        // Register bytes are addressed by byte offset over APB words
        a = paddr[9:2];
        if (rdEn) begin
            rdByte = regRead(st_reg, a);
            st_next.rdata = {24'h0, rdByte};
        end

        // Pin input synchroniser, a change counts once stages 2 and 3 agree
        st_next.inS1 = portIn;
        st_next.inS2 = st_reg.inS1;
        st_next.inS3 = st_reg.inS2;
        for (int b = 0; b < 4; b++) begin
            if (st_reg.inS2[b] == st_reg.inS3[b]) begin
                st_next.inStable[b] = st_reg.inS3[b];
            end
        end

        // Prescaler and scalers
        if (st_reg.chEn != 4'h0) begin
            st_next.presCnt = st_reg.presCnt + 7'd1;
        end
        if (tickA) begin
            // Scale 0 wraps through 8'hff, giving the divide by 256
            if (st_reg.scnt0 == 8'h01) begin
                st_next.scnt0 = st_reg.scal0;
                st_next.s0 = !st_reg.s0;
            end else begin
                st_next.scnt0 = st_reg.scnt0 - 8'h01;
            end
        end
        if (tickB) begin
            if (st_reg.scnt1 == 8'h01) begin
                st_next.scnt1 = st_reg.scal1;
                st_next.s1 = !st_reg.s1;
            end else begin
                st_next.scnt1 = st_reg.scnt1 - 8'h01;
            end
        end

        // Enabled channel joins at its next clock tick
        for (int c = 0; c < 4; c++) begin
            if (!st_reg.chEn[c]) begin
                st_next.live[c] = 1'b0;
            end else if (chTick[c]) begin
                st_next.live[c] = 1'b1;
            end
        end

        // Channel counters, done in pairs for concatenation
        for (int p = 0; p < 2; p++) begin
            int h, l;
            logic cat, go;
            h = 2 * p;
            l = 2 * p + 1;
            cat = st_reg.clkCtl[p == 0 ? POS_CON_LO : POS_CON_HI];
            go = 1'b0;
            for (int k = 0; k < 2; k++) begin
                int c;
                c = h + k;
                if (cat && k == 0) begin
                    continue;
                end
                if (cat) begin
                    c16 = {st_reg.cnt[h], st_reg.cnt[l]};
                    p16 = {st_reg.perAct[h], st_reg.perAct[l]};
                    d16 = {st_reg.dtyAct[h], st_reg.dtyAct[l]};
                    go = chEdge[l];
                end else begin
                    c16 = {8'h00, st_reg.cnt[c]};
                    p16 = {8'h00, st_reg.perAct[c]};
                    d16 = {8'h00, st_reg.dtyAct[c]};
                    go = chEdge[c];
                end
                top = c16 >= p16;
                bot = c16 == 16'h0000;
                lat = 1'b0;
                if (go) begin
                    if (!center_align_sel) begin
                        if (top) begin
                            c16 = 16'h0000;
                            lat = 1'b1;
                        end else begin
                            c16 = c16 + 16'h0001;
                        end
                    end else begin
                        // Count holds one tick at each turn: 2*(period+1) ticks a cycle
                        if (!st_reg.down[c] && top) begin
                            st_next.down[c] = 1'b1;
                        end else if (st_reg.down[c] && bot) begin
                            st_next.down[c] = 1'b0;
                            lat = 1'b1;
                        end else if (st_reg.down[c]) begin
                            c16 = c16 - 16'h0001;
                        end else begin
                            c16 = c16 + 16'h0001;
                        end
                    end
                    // Output level: start at polarity level, flip to the inverse once count passes duty
                    if (d16 >= p16 && d16 != 16'hffff) begin
                        st_next.wave[c] = st_reg.polSel[c];
                    end else if (c16 > d16 || d16 == 16'hffff) begin
                        st_next.wave[c] = !st_reg.polSel[c];
                    end else begin
                        st_next.wave[c] = st_reg.polSel[c];
                    end
                end
                if (cat) begin
                    st_next.cnt[h] = c16[15:8];
                    st_next.cnt[l] = c16[7:0];
                    st_next.wave[h] = st_next.wave[c];
                end else begin
                    st_next.cnt[c] = c16[7:0];
                end
                if (lat) begin
                    st_next.perAct[c] = st_reg.perBuf[c];
                    st_next.dtyAct[c] = st_reg.dtyBuf[c];
                    if (cat) begin
                        st_next.perAct[h] = st_reg.perBuf[h];
                        st_next.dtyAct[h] = st_reg.dtyBuf[h];
                    end
                end
            end
        end
        for (int c = 0; c < 4; c++) begin
            if (!st_reg.chEn[c]) begin
                st_next.perAct[c] = st_reg.perBuf[c];
                st_next.dtyAct[c] = st_reg.dtyBuf[c];
                st_next.down[c] = 1'b0;
            end
        end

        // Register writes take effect at the access edge
        if (wrEn) begin
            if (a == OFF_CLK) st_next.clkCtl = wrByte;
            if (a == OFF_POL) st_next.polSel = wrByte;
            if (a == OFF_EN) st_next.chEn = wrByte[3:0];
            if (a == OFF_SCAL0) begin
                st_next.scal0 = wrByte;
                st_next.scnt0 = wrByte;
            end
            if (a == OFF_SCAL1) begin
                st_next.scal1 = wrByte;
                st_next.scnt1 = wrByte;
            end
            if (a == OFF_CTL) st_next.ctl = wrByte[4:0];
            if (a == OFF_DDR) st_next.ddr = wrByte[3:0];
            if (a == OFF_PORT) st_next.portData = wrByte[3:0];
            if (a[7:2] == OFF_PER[7:2]) begin
                st_next.perBuf[a[1:0]] = wrByte;
                if (!st_reg.chEn[a[1:0]]) st_next.perAct[a[1:0]] = wrByte;
            end
            if (a[7:2] == OFF_DTY[7:2]) begin
                st_next.dtyBuf[a[1:0]] = wrByte;
                if (!st_reg.chEn[a[1:0]]) st_next.dtyAct[a[1:0]] = wrByte;
            end
            if (a[7:2] == OFF_CNT[7:2]) begin
                st_next.cnt[a[1:0]] = 8'h00;
                st_next.down[a[1:0]] = 1'b0;
                st_next.perAct[a[1:0]] = st_reg.perBuf[a[1:0]];
                st_next.dtyAct[a[1:0]] = st_reg.dtyBuf[a[1:0]];
            end
        end
    end

    // Pin mux: an enabled channel owns its pin; concatenated low byte pin stays port
    always_comb begin
        logic [3:0] owns;
        owns = st_reg.chEn & st_reg.live;
        if (st_reg.clkCtl[POS_CON_LO]) owns[1] = 1'b0;
        if (st_reg.clkCtl[POS_CON_HI]) owns[3] = 1'b0;
        if (st_reg.clkCtl[POS_CON_LO]) owns[0] = st_reg.chEn[1] && st_reg.live[1];
        if (st_reg.clkCtl[POS_CON_HI]) owns[2] = st_reg.chEn[3] && st_reg.live[3];
        for (int b = 0; b < 4; b++) begin
            portOut[b] = owns[b] ? st_reg.wave[b] : st_reg.portData[b];
            portOe[b] = st_reg.chEn[b] || st_reg.ddr[b];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// ---- tb/fpw_load.sv ----
// External loads sharing the port pins with the PWM core
module fpw_load (
    // Core side
    input wire logic [3:0] pinDrive,
    input wire logic [3:0] pinOe,
    // Outside world
    input wire logic [3:0] extLevel,
    output logic [3:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Outside source only wins where the core lets go of the pin
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pinLevel[i] = pinOe[i] ? pinDrive[i] : extLevel[i];
        end
    end
endmodule

// ---- tb/fpw_checker.sv ----
// Port-level assertions for the PWM core
module fpw_checker
    import fpw_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic [3:0] portIn,
    input wire logic [3:0] portOut,
    input wire logic [3:0] portOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] enSh;
    logic [3:0] ddrSh;
    logic [3:0] portSh;
    logic [7:0] polSh;
    wire wrAcc = psel & penable & pwrite;
    wire rdAcc = psel & penable & ~pwrite;
    wire rdSetup = psel & ~penable & ~pwrite;
    // Shadows of the enable, direction, port data and polarity registers, updated at the write edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            enSh <= 4'h0;
            ddrSh <= 4'h0;
            portSh <= 4'h0;
            polSh <= 8'h00;
        end else if (wrAcc) begin
            case (paddr[9:2])
                OFF_EN: enSh <= pwdata[3:0];
                OFF_DDR: ddrSh <= pwdata[3:0];
                OFF_PORT: portSh <= pwdata[3:0];
                OFF_POL: polSh <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_oe_follows_en: assert property (portOe == (enSh | ddrSh))
        else $error("pin drive not enable or direction");
    a_port_data_out: assert property (((portOut ^ portSh) & ~enSh) == 4'h0)
        else $error("disabled pin not showing port data");
    a_en_read_back: assert property (
        rdAcc && paddr[9:2] == OFF_EN |-> prdata == {28'h0, enSh})
        else $error("enable readback wrong");
    a_pol_read_back: assert property (
        rdAcc && paddr[9:2] == OFF_POL |-> prdata == {24'h0, polSh})
        else $error("polarity readback wrong");
    a_unmapped_zero: assert property (rdAcc && paddr[9:2] > 8'h56 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_no_error: assert property (!pslverr)
        else $error("pslverr high");
    a_read_data_hold: assert property ($changed(prdata) |-> $past(rdSetup))
        else $error("prdata moved outside a read");
    c_enable_write: cover property (wrAcc && paddr[9:2] == OFF_EN && pwdata[3:0] != 4'h0);
    c_counter_read: cover property (rdAcc && paddr[9:2] == OFF_CNT);
    c_wave_rise: cover property (enSh[0] && $rose(portOut[0]));
endmodule

bind fpw_core fpw_checker chk (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portIn(portIn), .portOut(portOut), .portOe(portOe));

// ---- tb/fpw_tb.sv ----
// Self-checking testbench for the PWM core
module tb
    import fpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] portIn;
    logic [3:0] portOut;
    logic [3:0] portOe;
    logic [3:0] ext = 4'ha;
    logic [31:0] q;
    logic [31:0] q2;
    int mismatches = 0;
    int nTests = 0;
    always #10 clock = ~clock;
    fpw_core dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portIn(portIn), .portOut(portOut), .portOe(portOe));
    fpw_load load (.pinDrive(portOut), .pinOe(portOe), .extLevel(ext), .pinLevel(portIn));
    task automatic closeOut;
        if (mismatches == 0 && nTests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, bounded by the watchdog
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
            output logic [31:0] r);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] z;
        xfer(1'b1, idx, d, z);
    endtask
    task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] z;
        xfer(1'b0, idx, 8'h00, z);
        check(z, {24'h0, exp});
    endtask
    task automatic meas(input int ch, input int cyc, input int exp);
        int n;
        n = 0;
        // Sample between edges, where the pin has settled
        repeat (cyc) begin
            @(negedge clock);
            if (portOut[ch] === 1'b1) n++;
        end
        check(32'(n), 32'(exp));
    endtask
    // Steady waveform: count high cycles over two whole periods
    task automatic run(input int ch, input int p, input int d, input int pol, input int ctr,
            input int pres, input int useS, input int sc);
        int dv;
        int base;
        int hi;
        dv = (1 << pres) * (useS != 0 ? 2 * sc : 1);
        base = 2 * dv * (ctr != 0 ? 2 * (p + 1) : p + 1);
        // Duty counts high time at polarity 1, low time at 0; doubled when centered
        hi = 2 * dv * (pol != 0 ? d + 1 : p - d) * (ctr != 0 ? 2 : 1);
        wr(OFF_EN, 8'h00);
        wr(OFF_CTL, 8'(ctr << POS_CENTER_ALIGN_SEL));
        wr(OFF_CLK, 8'((pres << POS_PCKA) | pres));
        wr(OFF_POL, 8'((useS << (4 + ch)) | (pol << ch)));
        wr(OFF_SCAL0, 8'(sc));
        wr(OFF_SCAL1, 8'(sc));
        wr(8'(OFF_PER + ch), 8'(p));
        wr(8'(OFF_DTY + ch), 8'(d));
        wr(8'(OFF_CNT + ch), 8'h00);
        wr(OFF_EN, 8'(1 << ch));
        @(negedge clock);
        check({31'h0, portOe[ch]}, 32'h1);
        rdChk(OFF_DDR, 8'h00);
        repeat (base) @(posedge clock);
        meas(ch, base, hi);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        closeOut();
    end
    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        rdChk(OFF_CLK, RST_CLK);
        rdChk(OFF_POL, RST_POL);
        rdChk(OFF_EN, RST_EN);
        check({28'h0, portOe}, 32'h0);
        wr(OFF_POL, 8'ha5);
        rdChk(OFF_POL, 8'ha5);
        wr(8'h60, 8'hff);
        rdChk(8'h60, 8'h00);
        repeat (5) @(posedge clock);
        rdChk(OFF_PORT, 8'h0a);
        wr(OFF_DDR, 8'h0f);
        wr(OFF_PORT, 8'h05);
        @(negedge clock);
        check({28'h0, portOut}, 32'h5);
        wr(OFF_DDR, 8'h00);
        // Nothing enabled since reset, so the prescaler must not have moved
        xfer(1'b0, OFF_PRES, 8'h00, q);
        repeat (10) @(posedge clock);
        xfer(1'b0, OFF_PRES, 8'h00, q2);
        check(q, 32'h0);
        check(q2, 32'h0);
        run(0, 9, 3, 1, 0, 0, 0, 1);
        run(1, 9, 0, 0, 0, 0, 0, 1);
        run(2, 7, 2, 1, 1, 0, 0, 1);
        run(3, 7, 2, 0, 1, 0, 0, 1);
        run(2, 4, 1, 1, 0, 2, 0, 1);
        run(1, 4, 1, 1, 0, 1, 1, 3);
        run(3, 5, 2, 0, 0, 0, 1, 2);
        run(0, 9, 3, 1, 0, 0, 0, 1);
        // Duty rewritten live, then forced in by a counter write
        wr(OFF_DTY, 8'h06);
        rdChk(OFF_DTY, 8'h06);
        wr(OFF_CNT, 8'h00);
        xfer(1'b0, OFF_CNT, 8'h00, q);
        check({31'h0, q < 32'h8}, 32'h1);
        repeat (20) @(posedge clock);
        meas(0, 20, 14);
        for (int k = 0; k < 2; k++) begin
            wr(OFF_EN, 8'h00);
            wr(OFF_CTL, 8'h00);
            wr(OFF_CLK, k != 0 ? 8'h80 : 8'h40);
            wr(OFF_POL, 8'(3 << (2 * k)));
            wr(8'(OFF_PER + 2 * k), 8'h01);
            wr(8'(OFF_PER + 2 * k + 1), 8'h03);
            wr(8'(OFF_DTY + 2 * k), 8'h00);
            wr(8'(OFF_DTY + 2 * k + 1), 8'h40);
            wr(8'(OFF_CNT + 2 * k), 8'h00);
            wr(8'(OFF_CNT + 2 * k + 1), 8'h00);
            wr(OFF_EN, 8'(3 << (2 * k)));
            repeat (520) @(posedge clock);
            meas(2 * k, 520, 130);
        end
        closeOut();
    end
endmodule
